// File: pkg/swo_pkg.sv
// Purpose: constants for the secondary window / sprite register block
// Assumes: 8-bit host i/o data, index/data port pair
// Notes: index values are the register selectors on the data port
package swo_pkg;
   localparam logic [7:0] IDX_HPOS_LO = 8'he0;
   localparam logic [7:0] IDX_HPOS_HI = 8'he1;
   localparam logic [7:0] IDX_WID_LO = 8'he2;
   localparam logic [7:0] IDX_WID_HI = 8'he3;
   localparam logic [7:0] IDX_VPOS_LO = 8'he4;
   localparam logic [7:0] IDX_VPOS_HI = 8'he5;
   localparam logic [7:0] IDX_HGT_LO = 8'he6;
   localparam logic [7:0] IDX_HGT_HI = 8'he7;
   localparam logic [7:0] IDX_SA_LO = 8'he8;
   localparam logic [7:0] IDX_SA_MID = 8'he9;
   localparam logic [7:0] IDX_SA_HI = 8'hea;
   localparam logic [7:0] IDX_ROW_LO = 8'heb;
   localparam logic [7:0] IDX_ROW_HI = 8'hec;
   localparam logic [7:0] IDX_CTRL = 8'hef;
   localparam logic [7:0] IDX_PORT_CTRL = 8'hf7;
   localparam logic [7:0] IDX_GROUP_BASE = 8'he0;
   localparam logic [7:0] IDX_IMG_BASE = 8'hf0;
   localparam int NUM_REGS = 16;
   localparam logic [7:0] INDEX_RESET = 8'h00;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [2:0] STRAP_RESET = 3'h0;
   localparam logic [3:0] PORT_LOW_INDEX = 4'ha;
   localparam logic [3:0] PORT_LOW_DATA = 4'hb;
   localparam logic [7:0] PORT_HIGH = 8'h21;
   localparam int CTRL_SELECT_BIT = 0;
   localparam int PORT_ENABLE_BIT = 7;
   localparam logic [7:0] NIBBLE_MASK = 8'h0f;
   localparam logic [7:0] PRESET_MASK = 8'h3f;
   localparam logic [7:0] CTRL_MASK = 8'h07;
   localparam logic [7:0] PORT_CTRL_MASK = 8'h83;
   localparam logic [5:0] SPRITE_LAST = 6'h3f;
endpackage

// File: pkg/swo_regs_if.sv
// Purpose: carries write and read traffic between decode and register store
// Assumes: single clock
// Notes: read data is registered in the store
interface swo_regs_if;
   logic wr;
   logic [3:0] waddr;
   logic [7:0] wdata;
   logic [3:0] raddr;
   logic [7:0] rdata;
   modport ctl (output wr, output waddr, output wdata, output raddr, input rdata);
   modport mem (input wr, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: core/swo_regstore.sv
// Purpose: 16 x 8 register store for indices e0..ef
// Assumes: reserved bits masked before write
// Notes: read data from a flip-flop, one cycle behind raddr
module swo_regstore
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register traffic
   swo_regs_if.mem bus,
   // whole store, for the timing logic
   output logic [7:0] regs [16]
);
   import swo_pkg::*;

   genvar i;
   for (i = 0; i < NUM_REGS; i++)
   begin : g_reg
      always_ff @(posedge core_clk or posedge rst)
      begin
         if (rst)
            regs[i] <= REG_RESET;
         else if (bus.wr && bus.waddr == 4'(i))
            regs[i] <= bus.wdata;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         bus.rdata <= REG_RESET;
      else
         bus.rdata <= regs[bus.raddr];
   end
endmodule

// File: core/swo_top.sv
// Purpose: secondary window / sprite indexed registers and field decode
// Assumes: host i/o cycles are synchronous one-cycle strobes on core_clk
// Notes: straps are pins and pass three flops before capture
//
// How it works
// - 8-bit index register selects data-port target
// - index port then data port, e0..ef
// - same index also reaches image-port registers
// - strap pins set port middle digit
// - horizontal position 12 bits, low/high
// - left edge at programmed pixel count
// - vertical position 12 bits, top edge
// - width/height meaning follows select bit
// - sprite horizontal preset 5:0, ends 63
// - sprite vertical preset 5:0, ends 63
// - start address 20 bits over three registers
// - start address counts doublewords
// - row offset low holds bits 7:0
// - row offset 12-bit quadword count
// - control bit 0: window set, sprite clear
// - port control bit 7 enables, resets zero
module swo_top
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // host i/o cycle
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_hit,
   // straps
   input wire logic [2:0] port_strap_pins,
   // window / sprite geometry to the display pipeline
   output logic [11:0] ovl_hpos,
   output logic [11:0] ovl_vpos,
   output logic [11:0] ovl_width_m1,
   output logic [11:0] ovl_height_m1,
   output logic [5:0] sprite_hpreset,
   output logic [5:0] sprite_vpreset,
   output logic [5:0] sprite_last,
   output logic [21:0] ovl_start_byte,
   output logic [11:0] ovl_row_qwords,
   output logic ovl_window_mode,
   output logic ovl_enable,
   // image-port group hook
   output logic img_sel,
   output logic [2:0] img_index
);
   import swo_pkg::*;

   // ----------------------------------------
   // straps
   // ----------------------------------------
   logic [2:0] strap_s1_reg;
   logic [2:0] strap_s2_reg;
   logic [2:0] strap_s3_reg;
   logic [2:0] strap_reg;
   logic strap_done_reg;
   // marks how far real pin levels have travelled down the three stages
   logic [2:0] strap_fill_reg;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         strap_s1_reg <= STRAP_RESET;
         strap_s2_reg <= STRAP_RESET;
         strap_s3_reg <= STRAP_RESET;
         strap_fill_reg <= 3'h0;
      end
      else
      begin
         strap_fill_reg <= {strap_fill_reg[1:0], 1'b1};
         strap_s1_reg <= port_strap_pins;
         strap_s2_reg <= strap_s1_reg;
         strap_s3_reg <= strap_s2_reg;
      end
   end

   // caught once after release, when second and third stages agree
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         strap_reg <= STRAP_RESET;
         strap_done_reg <= 1'b0;
      end
      // stages still hold reset values until the fill mark has passed stage three
      else if (!strap_done_reg && strap_fill_reg[2] && strap_s2_reg == strap_s3_reg)
      begin
         strap_reg <= strap_s3_reg;
         strap_done_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // port decode
   // ----------------------------------------
   logic [15:0] index_port;
   logic [15:0] data_port;
   logic index_hit;
   logic data_hit;

   assign index_port = {PORT_HIGH, 1'b0, strap_reg, PORT_LOW_INDEX};
   assign data_port = {PORT_HIGH, 1'b0, strap_reg, PORT_LOW_DATA};
   // no decode until straps are known
   assign index_hit = strap_done_reg && io_addr == index_port;
   assign data_hit = strap_done_reg && io_addr == data_port;
   assign io_hit = (index_hit || data_hit) && (io_wr || io_rd);

   // ----------------------------------------
   // index register
   // ----------------------------------------
   logic [7:0] index_reg;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         index_reg <= INDEX_RESET;
      else if (io_wr && index_hit)
         index_reg <= io_wdata;
   end

   logic in_group;
   logic in_img;
   assign in_group = index_reg[7:4] == IDX_GROUP_BASE[7:4];
   assign in_img = index_reg[7:3] == IDX_IMG_BASE[7:3];
   assign img_sel = in_img;
   assign img_index = index_reg[2:0];

   // ----------------------------------------
   // data port writes
   // ----------------------------------------
   function automatic logic [7:0] wmask(input logic [7:0] idx);
      logic [7:0] m;
      m = 8'hff;
      case (idx)
         IDX_HPOS_HI, IDX_WID_HI, IDX_VPOS_HI, IDX_HGT_HI,
         IDX_SA_HI, IDX_ROW_HI: m = NIBBLE_MASK;
         IDX_CTRL: m = CTRL_MASK;
         8'hed: m = 8'h07;
         default: m = 8'hff;
      endcase
      return m;
   endfunction

   swo_regs_if rif ();
   logic [7:0] regs [16];

   assign rif.wr = io_wr && data_hit && in_group;
   assign rif.waddr = index_reg[3:0];
   assign rif.wdata = io_wdata & wmask(index_reg); // reserved bits stay zero
   assign rif.raddr = index_reg[3:0];

   swo_regstore u_store
   (
      .core_clk (core_clk),
      .rst (rst),
      .bus (rif),
      .regs (regs)
   );

   // image-port control; only bit 7 and bits 1:0 exist here
   logic [7:0] port_ctrl_reg;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         port_ctrl_reg <= REG_RESET;
      else if (io_wr && data_hit && index_reg == IDX_PORT_CTRL)
         port_ctrl_reg <= io_wdata & PORT_CTRL_MASK;
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   // store read data lags one cycle, so select is registered alongside it
   logic [1:0] rsel_reg;
   logic [7:0] index_q_reg;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rsel_reg <= 2'h0;
         index_q_reg <= INDEX_RESET;
      end
      else
      begin
         index_q_reg <= index_reg;
         // only a read strobe may steer data onto io_rdata
         if (io_rd && index_hit)
            rsel_reg <= 2'h1;
         else if (io_rd && data_hit && in_group)
            rsel_reg <= 2'h2;
         else if (io_rd && data_hit && index_reg == IDX_PORT_CTRL)
            rsel_reg <= 2'h3;
         else
            rsel_reg <= 2'h0;
      end
   end

   always_comb
   begin
      case (rsel_reg)
         2'h1: io_rdata = index_q_reg;
         2'h2: io_rdata = rif.rdata;
         2'h3: io_rdata = port_ctrl_reg;
         default: io_rdata = 8'h00;
      endcase
   end

   // ----------------------------------------
   // field decode
   // ----------------------------------------
   logic [19:0] start_dw;

   assign ovl_hpos = {regs[1][3:0], regs[0]};
   assign ovl_vpos = {regs[5][3:0], regs[4]};
   assign ovl_window_mode = regs[15][CTRL_SELECT_BIT];
   assign ovl_enable = port_ctrl_reg[PORT_ENABLE_BIT];

   // width/height meaningful only in window mode, presets only in sprite mode
   assign ovl_width_m1 = ovl_window_mode ? {regs[3][3:0], regs[2]} : 12'h000;
   assign ovl_height_m1 = ovl_window_mode ? {regs[7][3:0], regs[6]} : 12'h000;
   assign sprite_hpreset = ovl_window_mode ? 6'h00 : regs[2][5:0];
   assign sprite_vpreset = ovl_window_mode ? 6'h00 : regs[6][5:0];
   assign sprite_last = SPRITE_LAST;

   assign start_dw = {regs[10][3:0], regs[9], regs[8]};
   assign ovl_start_byte = {start_dw, 2'b00};
   assign ovl_row_qwords = {regs[12][3:0], regs[11]};
endmodule

// File: verification/swo_top_checker.sv
// Purpose: port-level checks for swo_top
// Assumes: one clock, rst async high
// Notes: bound to every swo_top instance
module swo_top_checker
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // host cycle
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_rdata,
   input wire logic io_hit,
   // geometry
   input wire logic [11:0] ovl_hpos,
   input wire logic [11:0] ovl_vpos,
   input wire logic [11:0] ovl_width_m1,
   input wire logic [11:0] ovl_height_m1,
   input wire logic [5:0] sprite_hpreset,
   input wire logic [5:0] sprite_vpreset,
   input wire logic [5:0] sprite_last,
   input wire logic [21:0] ovl_start_byte,
   input wire logic [11:0] ovl_row_qwords,
   input wire logic ovl_window_mode,
   input wire logic ovl_enable
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sprite_end_a: assert property (sprite_last == 6'h3f)
      else $error("sprite end column wrong");
   start_align_a: assert property (ovl_start_byte[1:0] == 2'h0)
      else $error("start byte not doubleword aligned");
   sprite_size_a: assert property (!ovl_window_mode |-> ovl_width_m1 == 12'h0
      && ovl_height_m1 == 12'h0) else $error("size live in sprite mode");
   window_preset_a: assert property (ovl_window_mode |-> sprite_hpreset == 6'h0
      && sprite_vpreset == 6'h0) else $error("preset live in window mode");
   rdata_idle_a: assert property (!io_rd |=> io_rdata == 8'h00)
      else $error("read data without read");
   port_decode_a: assert property (io_hit |-> (io_wr || io_rd) && io_addr[15:8] == 8'h21
      && !io_addr[7] && io_addr[3:1] == 3'h5) else $error("bad port hit");
   geom_hold_a: assert property (!io_wr |=> $stable(ovl_hpos) && $stable(ovl_vpos)
      && $stable(ovl_start_byte)) else $error("geometry moved without write");
   mode_hold_a: assert property (!io_wr |=> $stable(ovl_enable) && $stable(ovl_window_mode)
      && $stable(ovl_row_qwords)) else $error("mode moved without write");
   cover property (io_rd && io_hit);
   cover property (ovl_enable && ovl_window_mode);
   cover property (ovl_enable && !ovl_window_mode);
endmodule
bind swo_top swo_top_checker i_swo_top_checker (.core_clk, .rst, .io_addr, .io_wr, .io_rd,
   .io_rdata, .io_hit, .ovl_hpos, .ovl_vpos, .ovl_width_m1, .ovl_height_m1, .sprite_hpreset,
   .sprite_vpreset, .sprite_last, .ovl_start_byte, .ovl_row_qwords, .ovl_window_mode,
   .ovl_enable);

// File: verification/tb.sv
// Purpose: self-checking bench for swo_top
// Assumes: straps random but fixed from time zero
// Notes: reads queue their expectation; monitor compares at mid-cycle
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import swo_pkg::*;
   logic core_clk = 0, rst = 1, io_wr = 0, io_rd = 0, io_hit, rd_d = 0, img_sel;
   logic [15:0] io_addr = 16'h0000;
   logic [7:0] io_wdata = 8'h00, io_rdata, pi, pd;
   logic [7:0] r [13];
   logic [7:0] exp_q [$];
   logic [2:0] port_strap_pins, img_index;
   logic [11:0] ovl_hpos, ovl_vpos, ovl_width_m1, ovl_height_m1, ovl_row_qwords;
   logic [5:0] sprite_hpreset, sprite_vpreset, sprite_last;
   logic [21:0] ovl_start_byte;
   logic ovl_window_mode, ovl_enable;
   int seed = 32'h4a9b;
   int fail_count = 0;
   int check_count = 0;
   swo_top i_swo_top (.core_clk, .rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_hit,
      .port_strap_pins, .ovl_hpos, .ovl_vpos, .ovl_width_m1, .ovl_height_m1, .sprite_hpreset,
      .sprite_vpreset, .sprite_last, .ovl_start_byte, .ovl_row_qwords, .ovl_window_mode,
      .ovl_enable, .img_sel, .img_index);
   always #50 core_clk = ~core_clk;
   task tally_and_finish;
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [21:0] got, input logic [21:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one strobe cycle; w=1 write, w=0 read
   task cyc(input logic w, input logic [7:0] p, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      io_wr = w;
      io_rd = !w;
      io_addr = {PORT_HIGH, p};
      io_wdata = d;
      @(posedge core_clk);
      #1;
      io_wr = 0;
      io_rd = 0;
   endtask
   task sr(input logic [7:0] idx, input logic [7:0] d);
      cyc(1, pi, idx);
      cyc(1, pd, d);
   endtask
   task gr(input logic [7:0] idx, input logic [7:0] e);
      cyc(1, pi, idx);
      exp_q.push_back(e);
      cyc(0, pd, 8'h00);
   endtask
   // read data is only valid the cycle after the strobe
   always @(posedge core_clk) rd_d <= io_rd;
   always @(negedge core_clk)
      if (rd_d)
         chk(22'(io_rdata), 22'(exp_q.pop_front()));
   initial
   begin
      port_strap_pins = 3'($random(seed));
      pi = {1'b0, port_strap_pins, PORT_LOW_INDEX};
      pd = {1'b0, port_strap_pins, PORT_LOW_DATA};
      repeat (5) @(posedge core_clk);
      #1 rst = 0;
      repeat (6) @(posedge core_clk);
      exp_q.push_back(INDEX_RESET);
      cyc(0, pi, 8'h00);
      chk(22'(ovl_enable), 22'h0);
      sr(IDX_CTRL, 8'hff);
      gr(IDX_CTRL, 8'h07);
      for (int i = 0; i < 13; i++)
      begin
         r[i] = 8'($random(seed));
         sr(IDX_GROUP_BASE + 8'(i), r[i]);
         if (i inside {1, 3, 5, 7, 10, 12})
            r[i] = r[i] & NIBBLE_MASK;
      end
      for (int i = 0; i < 13; i++)
         gr(IDX_GROUP_BASE + 8'(i), r[i]);
      chk(22'({ovl_window_mode, ovl_hpos}), 22'({1'b1, r[1][3:0], r[0]}));
      chk(22'(ovl_width_m1), 22'({r[3][3:0], r[2]}));
      chk(22'(ovl_vpos), 22'({r[5][3:0], r[4]}));
      chk(22'(ovl_height_m1), 22'({r[7][3:0], r[6]}));
      chk(ovl_start_byte, {r[10][3:0], r[9], r[8], 2'b00});
      chk(22'(ovl_row_qwords), 22'({r[12][3:0], r[11]}));
      sr(IDX_CTRL, 8'h00);
      chk(22'({ovl_window_mode, ovl_width_m1, sprite_hpreset}), 22'(r[2][5:0]));
      chk(22'({ovl_height_m1, sprite_vpreset}), 22'(r[6][5:0]));
      sr(IDX_PORT_CTRL, 8'hff);
      gr(IDX_PORT_CTRL, 8'h83);
      chk(22'({ovl_enable, img_sel, img_index}), 22'h1f);
      sr(8'h10, 8'h5a);
      gr(8'h10, 8'h00);
      // index write on a foreign middle digit must not land
      cyc(1, pi ^ 8'h10, IDX_HPOS_LO);
      exp_q.push_back(8'h10);
      cyc(0, pi, 8'h00);
      repeat (3) @(posedge core_clk);
      tally_and_finish;
   end
   initial
   begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      tally_and_finish;
   end
endmodule
